// *** hw/ttc_buf2.sv ***
module ttc_buf2 import ttc_pkg::*; #(
    parameter int W = 8
) (
    input  wire logic         i_core_clk,
    input  wire logic         i_rst_n,
    input  wire logic         i_ce,
    input  wire logic         i_in_valid,
    output logic              o_in_ready,
    input  wire logic [W-1:0] i_in_data,
    output logic              o_out_valid,
    input  wire logic         i_out_ready,
    output logic [W-1:0]      o_out_data
);
    typedef struct packed {
        logic [1:0][W-1:0] mem;
        logic              wp;
        logic              rp;
        logic [1:0]        cnt;
    } ttc_buf_t;

    ttc_buf_t b_reg;
    ttc_buf_t b_next;
    logic     push;
    logic     pop;

    assign o_in_ready  = b_reg.cnt != TTC_BUF_FULL;
    assign o_out_valid = b_reg.cnt != 2'h0;
    assign o_out_data  = b_reg.mem[b_reg.rp];

    always_comb begin
        b_next = b_reg;
        push   = i_in_valid && o_in_ready;
        pop    = o_out_valid && i_out_ready;
        if (push) begin
            b_next.mem[b_reg.wp] = i_in_data;
            b_next.wp            = ~b_reg.wp;
        end
        if (pop) begin
            b_next.rp = ~b_reg.rp;
        end
        b_next.cnt = 2'(b_reg.cnt + {1'b0, push} - {1'b0, pop});
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            b_reg <= '0;
        end else if (i_ce) begin
            b_reg <= b_next;
        end
    end
endmodule : ttc_buf2

// *** hw/ttc_core.sv ***
// Functional notes
// R1 - Link traffic only on signaling channels 0 and 16.
// R2 - Filter request holds sequencer until transfer ends.
// R3 - DMA puts filter results straight into result RAM.
// R4 - Messages: data bus, four controls, one interrupt.
// R5 - Samples are mu=255 companded.
// R6 - Waveform built from tables into synthesizer RAM.
// R7 - Stored waveform goes out on transmit PCM bus.
// R8 - Timer from microseconds to 56 s; expiry resets sequencer.
// R9 - Frame counter paces output.
// R10 - Frequency 4 Hz to 3996 Hz in 4 Hz steps.
// R11 - Level -60 dBm to +3 dBm.
// R12 - Sequencer: 12 kbyte instructions, 2 kbyte results.
// R13 - Synthesizer: 8 kbyte tables, 2 kbyte waveform RAM.
// R14 - Sequencer writes filter-select RAM, reads filter PROM.
// R15 - Finished test results go to central controller.
// R16 - One sample per frame on its channel.
module ttc_core import ttc_pkg::*; #(
    parameter logic [25:0] P_TMR_MAX_US = TTC_TMR_MAX_US
) (
    input  wire logic       i_core_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_ce,
    input  wire logic       i_rx_valid,
    input  wire logic [4:0] i_rx_chan,
    input  wire logic [7:0] i_rx_data,
    output logic            o_sig_valid,
    output logic [4:0]      o_sig_chan,
    output logic [7:0]      o_sig_data,
    input  wire logic       i_sig_ready,
    input  wire logic       i_frame,
    output logic            o_tx_valid,
    output logic [4:0]      o_tx_chan,
    output logic [7:0]      o_tx_data,
    input  wire logic       i_tx_ready,
    input  wire logic       i_fc_req,
    input  wire logic       i_fc_valid,
    input  wire logic [7:0] i_fc_data,
    output logic            o_fc_grant,
    output logic            o_tsp_hold,
    output logic [3:0]      o_fc_addr,
    output logic [7:0]      o_fc_wdata,
    output logic            o_fc_wr,
    output logic            o_fc_rd,
    input  wire logic [7:0] i_fc_rdata,
    output logic            o_tsp_reset,
    output logic            o_tone_irq
);
    ////////////////////////////////////////////////////////////////////////////
    // Memories and state

    logic [7:0]  res_mem [TTC_TSP_RAM_BYTES];
    logic [7:0]  wave_mem [TTC_SYN_RAM_BYTES];
    ttc_st_t     st_reg;
    ttc_st_t     st_next;
    logic        res_we;
    logic [10:0] res_wa;
    logic [7:0]  res_wd;
    logic        wave_we;
    logic        buf_in_ready;
    logic        msg_busy;
    logic        hold_ok;
    logic [18:0] ph_x;
    logic [5:0]  sidx;
    logic [12:0] mag;
    logic [5:0]  att;
    logic [21:0] prod;
    logic [12:0] amp;
    logic [7:0]  tone_code;
    logic [11:0] ph_sum;
    logic [19:0] tmr_mul;
    logic [29:0] tmr_prod;
    logic [25:0] tmr_val;

    ////////////////////////////////////////////////////////////////////////////
    // Tone sample construction

    assign ph_x      = 19'(st_reg.phase) * TTC_PH_SCALE;
    assign sidx      = ph_x[17:12];
    assign mag       = ttc_sine(sidx[4] ? 5'(5'h10 - {1'b0, sidx[3:0]}) : {1'b0, sidx[3:0]}); // [R6]
    assign att       = TTC_LVL_MAX - st_reg.lvl; // [R11]
    assign prod      = 22'(mag) * 22'(ttc_fine(3'(att % TTC_LVL_STEP)));
    assign amp       = 13'((prod >> 8) >> (att / TTC_LVL_STEP));
    assign tone_code = ttc_mulaw(sidx[5], amp); // [R5]
    assign ph_sum    = 12'(st_reg.phase) + 12'(st_reg.step); // [R10]

    ////////////////////////////////////////////////////////////////////////////
    // Timer interval decode

    always_comb begin
        case (st_reg.arg[11:10])
            2'h0:    tmr_mul = TTC_MUL_US;
            2'h1:    tmr_mul = TTC_MUL_MS;
            default: tmr_mul = TTC_MUL_S;
        endcase
        tmr_prod = 30'(st_reg.arg[9:0]) * 30'(tmr_mul);
        tmr_val  = (tmr_prod > 30'(P_TMR_MAX_US)) ? P_TMR_MAX_US : tmr_prod[25:0]; // [R8]
    end

    assign msg_busy = st_reg.msg.strb || st_reg.msg.ack;
    assign hold_ok  = !st_reg.sig_valid && !msg_busy && !st_reg.fc_rd && !st_reg.fc_rd_d;

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        st_next         = st_reg;
        st_next.irq     = 1'b0;
        st_next.timeout = 1'b0;
        st_next.fc_wr   = 1'b0;
        st_next.fc_rd   = 1'b0;
        st_next.fc_rd_d = st_reg.fc_rd;
        res_we          = 1'b0;
        res_wa          = st_reg.res_ptr;
        res_wd          = i_fc_data;
        wave_we         = 1'b0;

        // Command assembly
        if (i_rx_valid && i_rx_chan == TTC_CH_OP) begin // [R1]
            st_next.op        = i_rx_data[7:4];
            st_next.arg[11:8] = i_rx_data[3:0];
            st_next.op_seen   = 1'b1;
        end else if (i_rx_valid && i_rx_chan == TTC_CH_ARG && st_reg.op_seen) begin // [R1]
            st_next.arg[7:0] = i_rx_data;
            st_next.op_seen  = 1'b0;
            st_next.cmd_pend = 1'b1;
        end

        // Timeout timer
        if (st_reg.tmr_on) begin
            if (st_reg.pre == TTC_PRE_LAST) begin
                st_next.pre = 5'h00;
                if (st_reg.tmr == 26'h0000001) begin
                    st_next.timeout = 1'b1; // [R8]
                    st_next.tmr_on  = 1'b0;
                    st_next.tmr     = 26'h0000000;
                end else begin
                    st_next.tmr = st_reg.tmr - 26'h0000001;
                end
            end else begin
                st_next.pre = st_reg.pre + 5'h01;
            end
        end

        // Message request
        if (st_reg.msg.ack) begin
            st_next.msg.strb = 1'b0; // [R4]
        end
        if (st_reg.cmd_pend && !st_reg.hold && !msg_busy) begin
            st_next.cmd_pend = 1'b0;
            st_next.msg.data = st_reg.arg;
            case (ttc_op_t'(st_reg.op))
                OP_FREQ: begin
                    st_next.msg.strb = 1'b1;
                    st_next.msg.sel  = MSG_FREQ;
                end
                OP_LEVEL: begin
                    st_next.msg.strb = 1'b1;
                    st_next.msg.sel  = MSG_LEVEL;
                end
                OP_START: begin
                    st_next.chan     = st_reg.arg[4:0]; // [R16]
                    st_next.msg.strb = 1'b1;
                    st_next.msg.sel  = MSG_RUN;
                end
                OP_STOP: begin
                    st_next.msg.strb = 1'b1;
                    st_next.msg.sel  = MSG_HALT;
                    st_next.rep_left = {1'b0, st_reg.res_ptr}; // [R15]
                    st_next.rep_idx  = 11'h000;
                    st_next.rep_hi   = 1'b0;
                    st_next.res_ptr  = 11'h000;
                end
                OP_TIMER: begin
                    st_next.tmr_load = tmr_val;
                    st_next.tmr      = tmr_val;
                    st_next.tmr_on   = tmr_val != 26'h0000000;
                    st_next.pre      = 5'h00;
                end
                OP_KICK: begin
                    st_next.tmr    = st_reg.tmr_load;
                    st_next.tmr_on = st_reg.tmr_load != 26'h0000000;
                    st_next.pre    = 5'h00;
                end
                OP_FCWR: begin
                    st_next.fc_addr  = st_reg.arg[11:8]; // [R14]
                    st_next.fc_wdata = st_reg.arg[7:0];
                    st_next.fc_wr    = 1'b1;
                end
                OP_FCRD: begin
                    st_next.fc_addr = st_reg.arg[11:8]; // [R14]
                    st_next.fc_rd   = 1'b1;
                end
                default: begin
                end
            endcase
        end

        // Message accept
        if (st_reg.msg.strb && !st_reg.msg.ack) begin
            st_next.msg.ack = 1'b1; // [R4]
            case (st_reg.msg.sel)
                MSG_FREQ: begin
                    if (st_reg.msg.data[9:0] == 10'h000) begin // [R10]
                        st_next.step = TTC_STEP_MIN;
                    end else if (st_reg.msg.data > TTC_STEP_MAX) begin
                        st_next.step = TTC_STEP_MAX[9:0];
                    end else begin
                        st_next.step = st_reg.msg.data[9:0];
                    end
                end
                MSG_LEVEL: begin
                    st_next.lvl = (st_reg.msg.data > 12'(TTC_LVL_MAX)) ? TTC_LVL_MAX : st_reg.msg.data[5:0]; // [R11]
                end
                MSG_RUN: begin
                    st_next.tone  = TONE_BUILD;
                    st_next.bidx  = 11'h000;
                    st_next.phase = 11'h000;
                end
                default: begin
                    st_next.tone = TONE_IDLE;
                end
            endcase
        end else if (!st_reg.msg.strb) begin
            st_next.msg.ack = 1'b0;
        end

        // Waveform build
        if (st_reg.tone == TONE_BUILD) begin
            wave_we       = 1'b1; // [R6]
            st_next.bidx  = st_reg.bidx + 11'h001;
            st_next.phase = (ph_sum >= 12'(TTC_WAVE_LEN)) ? 11'(ph_sum - 12'(TTC_WAVE_LEN)) : ph_sum[10:0];
            if (st_reg.bidx == TTC_WAVE_LEN - 11'h001) begin
                st_next.tone    = TONE_RUN;
                st_next.frm_cnt = 11'h000;
                st_next.irq     = 1'b1; // [R4]
            end
        end

        // Frame output
        if (st_reg.pend && buf_in_ready) begin
            st_next.pend = 1'b0;
        end
        if (i_frame && (!st_reg.pend || buf_in_ready)) begin
            st_next.pend = 1'b1; // [R16]
            if (st_reg.tone == TONE_RUN) begin
                st_next.smp     = wave_mem[st_reg.frm_cnt]; // [R7]
                st_next.frm_cnt = (st_reg.frm_cnt == TTC_WAVE_LEN - 11'h001) ? 11'h000
                                  : st_reg.frm_cnt + 11'h001; // [R9]
            end else begin
                st_next.smp = TTC_IDLE;
            end
        end

        // Filter DMA
        case (st_reg.dma)
            DMA_IDLE: begin
                if (i_fc_req) begin
                    st_next.dma  = DMA_HOLD;
                    st_next.hold = 1'b1; // [R2]
                end
            end
            DMA_HOLD: begin
                if (hold_ok) begin
                    st_next.dma   = DMA_XFER;
                    st_next.grant = 1'b1;
                end
            end
            DMA_XFER: begin
                if (i_fc_valid) begin
                    res_we          = 1'b1; // [R3]
                    st_next.res_ptr = (st_reg.res_ptr == TTC_RES_LAST) ? st_reg.res_ptr
                                  : st_reg.res_ptr + 11'h001;
                end
                if (!i_fc_req) begin
                    st_next.dma   = DMA_DONE;
                    st_next.grant = 1'b0;
                end
            end
            DMA_DONE: begin
                st_next.dma  = DMA_IDLE;
                st_next.hold = 1'b0; // [R2]
            end
            default: begin
                st_next.dma = DMA_IDLE;
            end
        endcase

        // Filter read data
        if (st_reg.fc_rd_d) begin
            res_we          = 1'b1; // [R14]
            res_wd          = i_fc_rdata;
            st_next.res_ptr = (st_reg.res_ptr == TTC_RES_LAST) ? st_reg.res_ptr : st_reg.res_ptr + 11'h001;
        end

        // Result report
        if (st_reg.sig_valid && i_sig_ready) begin
            st_next.sig_valid = 1'b0;
        end
        if (!st_reg.hold && st_reg.rep_left != 12'h000 && (!st_reg.sig_valid || i_sig_ready)) begin
            st_next.sig_valid = 1'b1; // [R15]
            st_next.sig_data  = res_mem[st_reg.rep_idx];
            st_next.sig_chan  = st_reg.rep_hi ? TTC_CH_ARG : TTC_CH_OP; // [R1]
            st_next.rep_hi    = ~st_reg.rep_hi;
            st_next.rep_idx   = st_reg.rep_idx + 11'h001;
            st_next.rep_left  = st_reg.rep_left - 12'h001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_reg <= TTC_ST_RST;
        end else if (i_ce) begin
            st_reg <= st_next;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_ce && res_we) begin
            res_mem[res_wa] <= res_wd; // [R12]
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_ce && wave_we) begin
            wave_mem[st_reg.bidx] <= tone_code; // [R13]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Transmit buffer and outputs

    ttc_buf2 #(
        .W (8)
    ) u_txbuf (
        .i_core_clk  (i_core_clk),
        .i_rst_n     (i_rst_n),
        .i_ce        (i_ce),
        .i_in_valid  (st_reg.pend),
        .o_in_ready  (buf_in_ready),
        .i_in_data   (st_reg.smp),
        .o_out_valid (o_tx_valid),
        .i_out_ready (i_tx_ready),
        .o_out_data  (o_tx_data)
    );

    assign o_tx_chan   = st_reg.chan;
    assign o_sig_valid = st_reg.sig_valid;
    assign o_sig_chan  = st_reg.sig_chan;
    assign o_sig_data  = st_reg.sig_data;
    assign o_fc_grant  = st_reg.grant;
    assign o_tsp_hold  = st_reg.hold;
    assign o_fc_addr   = st_reg.fc_addr;
    assign o_fc_wdata  = st_reg.fc_wdata;
    assign o_fc_wr     = st_reg.fc_wr;
    assign o_fc_rd     = st_reg.fc_rd;
    assign o_tsp_reset = st_reg.timeout;
    assign o_tone_irq  = st_reg.irq;
endmodule : ttc_core

// *** hw/ttc_pkg.sv ***
package ttc_pkg;
    localparam int          TTC_CLK_NS     = 50;
    localparam int          TTC_US_NS      = 1000;
    localparam int          TTC_US_CYC     = (TTC_US_NS + TTC_CLK_NS - 1) / TTC_CLK_NS;
    localparam logic [4:0]  TTC_PRE_LAST   = 5'(TTC_US_CYC - 1);
    localparam int          TTC_TMR_MAX_S  = 56;
    localparam logic [25:0] TTC_TMR_MAX_US = 26'(TTC_TMR_MAX_S * 1000000);
    localparam logic [19:0] TTC_MUL_US     = 20'h00001;
    localparam logic [19:0] TTC_MUL_MS     = 20'h003e8;
    localparam logic [19:0] TTC_MUL_S      = 20'hf4240;
    localparam logic [4:0]  TTC_CH_OP      = 5'h00;
    localparam logic [4:0]  TTC_CH_ARG     = 5'h10;
    localparam int          TTC_TSP_PROM_BYTES = 12288;
    localparam int          TTC_TSP_RAM_BYTES  = 2048;
    localparam int          TTC_SYN_PROM_BYTES = 8192;
    localparam int          TTC_SYN_RAM_BYTES  = 2048;
    localparam logic [10:0] TTC_WAVE_LEN   = 11'h7d0;
    localparam logic [10:0] TTC_RES_LAST   = 11'h7ff;
    localparam logic [11:0] TTC_STEP_MAX   = 12'h3e7;
    localparam logic [9:0]  TTC_STEP_MIN   = 10'h001;
    localparam logic [5:0]  TTC_LVL_MAX    = 6'h3f;
    localparam logic [5:0]  TTC_LVL_STEP   = 6'h06;
    localparam logic [18:0] TTC_PH_SCALE   = 19'h00083;
    localparam logic [13:0] TTC_MU_BIAS    = 14'h0021;
    localparam logic [13:0] TTC_MU_CLIP    = 14'h1fff;
    localparam logic [7:0]  TTC_IDLE       = 8'hff;
    localparam logic [1:0]  TTC_BUF_FULL   = 2'h2;

    typedef enum logic [3:0] {
        OP_NOP = 4'h0, OP_FREQ = 4'h1, OP_LEVEL = 4'h2, OP_START = 4'h3, OP_STOP = 4'h4,
        OP_TIMER = 4'h5, OP_KICK = 4'h6, OP_FCWR = 4'h7, OP_FCRD = 4'h8
    } ttc_op_t;
    typedef enum logic [1:0] {MSG_FREQ = 2'b00, MSG_LEVEL = 2'b01, MSG_RUN = 2'b10, MSG_HALT = 2'b11} ttc_sel_t;
    typedef enum logic [1:0] {DMA_IDLE = 2'b00, DMA_HOLD = 2'b01, DMA_XFER = 2'b10, DMA_DONE = 2'b11} ttc_dma_t;
    typedef enum logic [1:0] {TONE_IDLE = 2'b00, TONE_BUILD = 2'b01, TONE_RUN = 2'b10} ttc_tone_t;

    typedef struct packed {
        logic [11:0] data;
        ttc_sel_t    sel;
        logic        strb;
        logic        ack;
    } ttc_msg_t;

    typedef struct packed {
        logic [3:0]  op;
        logic [11:0] arg;
        logic        op_seen;
        logic        cmd_pend;
        ttc_msg_t    msg;
        logic        irq;
        logic [9:0]  step;
        logic [5:0]  lvl;
        logic [4:0]  chan;
        ttc_tone_t   tone;
        logic [10:0] bidx;
        logic [10:0] phase;
        logic [10:0] frm_cnt;
        logic [7:0]  smp;
        logic        pend;
        logic        tmr_on;
        logic [4:0]  pre;
        logic [25:0] tmr;
        logic [25:0] tmr_load;
        logic        timeout;
        ttc_dma_t    dma;
        logic        hold;
        logic        grant;
        logic [10:0] res_ptr;
        logic [3:0]  fc_addr;
        logic [7:0]  fc_wdata;
        logic        fc_wr;
        logic        fc_rd;
        logic        fc_rd_d;
        logic [11:0] rep_left;
        logic [10:0] rep_idx;
        logic        rep_hi;
        logic        sig_valid;
        logic [4:0]  sig_chan;
        logic [7:0]  sig_data;
    } ttc_st_t;

    localparam ttc_st_t TTC_ST_RST = '0;

    // Quarter-wave sine table
    function automatic logic [12:0] ttc_sine(input logic [4:0] i);
        case (i)
            5'h00: return 13'h0000;
            5'h01: return 13'h0313;
            5'h02: return 13'h061f;
            5'h03: return 13'h091b;
            5'h04: return 13'h0c01;
            5'h05: return 13'h0eca;
            5'h06: return 13'h116e;
            5'h07: return 13'h13e7;
            5'h08: return 13'h162f;
            5'h09: return 13'h1840;
            5'h0a: return 13'h1a16;
            5'h0b: return 13'h1bab;
            5'h0c: return 13'h1cfc;
            5'h0d: return 13'h1e05;
            5'h0e: return 13'h1ec5;
            5'h0f: return 13'h1f38;
            default: return 13'h1f5f;
        endcase
    endfunction : ttc_sine

    // Fine gain, 256 = unity
    function automatic logic [8:0] ttc_fine(input logic [2:0] i);
        case (i)
            3'h0: return 9'h100;
            3'h1: return 9'h0e4;
            3'h2: return 9'h0cb;
            3'h3: return 9'h0b5;
            3'h4: return 9'h0a1;
            default: return 9'h090;
        endcase
    endfunction : ttc_fine

    // Mu=255 compander
    function automatic logic [7:0] ttc_mulaw(input logic neg, input logic [12:0] mag);
        logic [13:0] b;
        logic [2:0]  seg;
        logic [3:0]  man;
        b = {1'b0, mag} + TTC_MU_BIAS;
        if (b > TTC_MU_CLIP) begin
            b = TTC_MU_CLIP;
        end
        seg = 3'h0;
        for (int s = 1; s < 8; s++) begin
            if (b[s + 5]) begin
                seg = 3'(s);
            end
        end
        man = 4'(b >> ({1'b0, seg} + 4'h1));
        return ~{neg, seg, man};
    endfunction : ttc_mulaw
endpackage : ttc_pkg

// *** verif/ttc_core_properties.sv ***
module ttc_chk (
    input wire logic       i_core_clk,
    input wire logic       i_rst_n,
    input wire logic       i_fc_req,
    input wire logic       i_frame,
    input wire logic       i_sig_ready,
    input wire logic       i_tx_ready,
    input wire logic       o_fc_grant,
    input wire logic       o_tsp_hold,
    input wire logic       o_sig_valid,
    input wire logic [4:0] o_sig_chan,
    input wire logic [7:0] o_sig_data,
    input wire logic       o_tx_valid,
    input wire logic [7:0] o_tx_data,
    input wire logic       o_fc_wr,
    input wire logic       o_tsp_reset
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);
    a_hold_before_grant: assert property ($rose(o_fc_grant) |-> $past(o_tsp_hold))
        else $error("grant without hold");
    a_grant_in_hold: assert property (o_fc_grant |-> o_tsp_hold)
        else $error("grant outside hold");
    a_hold_release: assert property ($fell(o_fc_grant) |=> !o_tsp_hold)
        else $error("hold not released");
    a_dma_start: assert property ($rose(i_fc_req) && !o_tsp_hold && !o_fc_grant |=> o_tsp_hold)
        else $error("no hold on request");
    a_sig_chan_legal: assert property (o_sig_valid |-> o_sig_chan == 5'h00 || o_sig_chan == 5'h10)
        else $error("report on wrong channel");
    a_sig_stall_hold: assert property (o_sig_valid && !i_sig_ready |=> o_sig_valid && $stable(o_sig_data))
        else $error("report byte lost");
    a_tx_stall_hold: assert property (o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_data))
        else $error("tone word lost");
    a_frame_to_word: assert property (i_frame && !o_tx_valid |-> ##2 o_tx_valid)
        else $error("frame not paced out");
    a_fc_wr_pulse: assert property (o_fc_wr |=> !o_fc_wr)
        else $error("write strobe too long");
    a_timeout_pulse: assert property (o_tsp_reset |=> !o_tsp_reset)
        else $error("timeout pulse too long");
endmodule : ttc_chk

bind ttc_core ttc_chk u_chk (.*);

// *** verif/ttc_core_tb.sv ***
module ttc_core_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import ttc_pkg::*;
    logic       i_core_clk, i_rst_n, i_ce, i_rx_valid, i_sig_ready, i_frame, i_tx_ready, go;
    logic       i_fc_req, i_fc_valid, o_sig_valid, o_tx_valid, o_fc_grant, o_tsp_hold, o_fc_wr;
    logic       o_fc_rd, o_tsp_reset, o_tone_irq;
    logic [4:0] i_rx_chan, o_sig_chan, o_tx_chan;
    logic [7:0] i_rx_data, i_fc_data, i_fc_rdata, o_sig_data, o_tx_data, o_fc_wdata;
    logic [3:0] o_fc_addr;
    int         err_count = 0;
    int         checks_done = 0;

    ttc_core #(.P_TMR_MAX_US(26'd100)) dut (.*);
    ttc_fc_model u_fc (.i_clk(i_core_clk), .i_go(go), .i_grant(o_fc_grant), .i_wr(o_fc_wr),
        .i_rd(o_fc_rd), .i_addr(o_fc_addr), .i_wdata(o_fc_wdata), .o_req(i_fc_req),
        .o_valid(i_fc_valid), .o_data(i_fc_data), .o_rdata(i_fc_rdata));

    ////////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("Checks made %0d, errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : tally_and_finish
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(negedge i_core_clk);
    endtask : tick
    task automatic limit(input int k, input int max);
        if (k >= max) begin
            chk("wait_bound", 8'h00, 8'h01);
            tally_and_finish();
        end
    endtask : limit
    task automatic rx(input logic [4:0] ch, input logic [7:0] d);
        i_rx_valid = 1'b1;
        i_rx_chan  = ch;
        i_rx_data  = d;
        tick(1);
    endtask : rx
    task automatic cmd(input logic [3:0] op, input logic [11:0] arg);
        rx(5'h00, {op, arg[11:8]});
        rx(5'h10, arg[7:0]);
        i_rx_valid = 1'b0;
        tick(8);
    endtask : cmd
    task automatic get_sig(input logic [4:0] ch, input logic [7:0] d);
        int k;
        for (k = 0; k < 60 && o_sig_valid !== 1'b1; k++) tick(1);
        limit(k, 60);
        chk("sig_chan", {3'h0, ch}, {3'h0, o_sig_chan});
        chk("sig_data", d, o_sig_data);
        i_sig_ready = 1'b1;
        tick(1);
        i_sig_ready = 1'b0;
        tick(1);
    endtask : get_sig
    task automatic frame_word(output logic [7:0] d);
        int k;
        i_frame = 1'b1;
        tick(1);
        i_frame = 1'b0;
        for (k = 0; k < 8 && o_tx_valid !== 1'b1; k++) tick(1);
        limit(k, 8);
        d = o_tx_data;
        tick(4);
    endtask : frame_word

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_filter();
        int n = 0;
        rx(5'h03, {OP_FCWR, 4'h3});
        rx(5'h10, 8'h11);
        i_rx_valid = 1'b0;
        for (int k = 0; k < 8; k++) begin
            n += int'(o_fc_wr === 1'b1);
            tick(1);
        end
        chk("stray_wr", 8'h00, 8'(n));
        cmd(OP_FCWR, {4'h3, 8'h5a});
        cmd(OP_FCRD, 12'h300);
        cmd(OP_STOP, 12'h000);
        get_sig(5'h00, 8'h5a);
    endtask : t_filter
    task automatic t_dma();
        int k;
        go = 1'b1;
        tick(1);
        go = 1'b0;
        for (k = 0; k < 20 && o_tsp_hold !== 1'b1; k++) tick(1);
        limit(k, 20);
        chk("grant_early", 8'h00, {7'h0, o_fc_grant});
        for (k = 0; k < 40 && o_tsp_hold !== 1'b0; k++) tick(1);
        limit(k, 40);
        cmd(OP_STOP, 12'h000);
        get_sig(5'h00, 8'ha0);
        get_sig(5'h10, 8'ha1);
        get_sig(5'h00, 8'ha2);
    endtask : t_dma
    task automatic t_tone();
        int k;
        int n;
        logic [7:0] d;
        frame_word(d);
        chk("idle_word", 8'hff, d);
        cmd(OP_FREQ, 12'h0fa);
        cmd(OP_LEVEL, 12'h03f);
        cmd(OP_START, 12'h005);
        for (k = 0; k < 2100 && o_tone_irq !== 1'b1; k++) tick(1);
        limit(k, 2100);
        chk("tx_chan", 8'h05, {3'h0, o_tx_chan});
        n = 0;
        for (k = 0; k < 4; k++) begin
            frame_word(d);
            n += int'(d !== 8'hff);
        end
        chk("tone_live", 8'h00, 8'(n == 0));
        i_tx_ready = 1'b0;
        for (k = 0; k < 4; k++) begin
            frame_word(d);
        end
        n = 0;
        i_tx_ready = 1'b1;
        for (k = 0; k < 10; k++) begin
            n += int'(o_tx_valid === 1'b1);
            tick(1);
        end
        chk("drained", 8'h03, 8'(n));
        cmd(OP_STOP, 12'h000);
        frame_word(d);
        chk("idle_after", 8'hff, d);
    endtask : t_tone
    task automatic t_timer();
        int k;
        cmd(OP_TIMER, 12'h003);
        cmd(OP_KICK, 12'h000);
        for (k = 9; k < 200 && o_tsp_reset !== 1'b1; k++) tick(1);
        limit(k, 200);
        chk("tmr_early", 8'h00, 8'(k < 60));
        chk("tmr_late", 8'h00, 8'(k > 85));
    endtask : t_timer

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        i_core_clk = 1'b0;
        forever #25 i_core_clk = ~i_core_clk;
    end
    initial begin
        {i_rst_n, i_rx_valid, i_sig_ready, i_frame, go, i_rx_chan, i_rx_data} = '0;
        i_ce = 1'b1;
        i_tx_ready = 1'b1;
        tick(5);
        i_rst_n = 1'b1;
        tick(2);
        t_filter();
        t_dma();
        t_tone();
        t_timer();
        tally_and_finish();
    end
endmodule : ttc_core_tb

// *** verif/ttc_fc_model.sv ***
module ttc_fc_model (
    input  wire logic       i_clk,
    input  wire logic       i_go,
    input  wire logic       i_grant,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    input  wire logic [3:0] i_addr,
    input  wire logic [7:0] i_wdata,
    output logic            o_req,
    output logic            o_valid,
    output logic [7:0]      o_data,
    output logic [7:0]      o_rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] mem_reg [16];
    logic [1:0] left_reg;
    initial begin
        {o_req, o_valid, o_data, o_rdata, left_reg} = '0;
    end
    always @(posedge i_clk) begin
        if (i_wr) mem_reg[i_addr] <= i_wdata;
        o_rdata <= i_rd ? mem_reg[i_addr] : ~o_rdata;
        o_valid <= 1'b0;
        o_data  <= ~o_data;
        if (i_go && !o_req) begin
            o_req    <= 1'b1;
            left_reg <= 2'h3;
        end else if (o_req && i_grant && left_reg != 2'h0) begin
            o_valid  <= 1'b1;
            o_data   <= 8'ha3 - {6'h0, left_reg};
            left_reg <= left_reg - 2'h1;
        end else if (o_req && i_grant) begin
            o_req <= 1'b0;
        end
    end
endmodule : ttc_fc_model
